/* File: aux_adc_consts.vh */
`ifndef AUX_ADC_CONSTS_VH
`define AUX_ADC_CONSTS_VH

// Control word fields.
`define CTL_STOP        14
`define CTL_SCAN_HI     13
`define CTL_SCAN_LO     10
`define CTL_WIDTH_HI    9
`define CTL_WIDTH_LO    8
`define CTL_AVG_HI      7
`define CTL_AVG_LO      6
`define CTL_RATE_HI     5
`define CTL_RATE_LO     4
`define CTL_FILT        0

// Serial command word fields.
`define CMD_READ        15
`define CMD_PAGE_HI     14
`define CMD_PAGE_LO     11
`define CMD_ADDR_HI     10
`define CMD_ADDR_LO     5

// Pages and register addresses.
`define PAGE_DATA       4'h0
`define PAGE_CTRL       4'h1
`define ADDR_CONTROL    6'h00
`define ADDR_STATUS     6'h01
`define ADDR_FIRST_BATTERY_INPUT       6'h05
`define ADDR_SECOND_BATTERY_INPUT       6'h06
`define ADDR_AUX        6'h07
`define ADDR_FIRST_THERMAL_MEASUREMENT      6'h09
`define ADDR_SECOND_THERMAL_MEASUREMENT      6'h0A

// Status word bits.
`define STAT_PWRDN      13
`define STAT_READY      11

// Scan selection codes; the first battery code is a parameter default.
`define SCAN_NONE       4'h0
`define SCAN_FIRST_BATTERY_INPUT       4'h5
`define SCAN_SECOND_BATTERY_INPUT       4'h7
`define SCAN_AUX        4'h8
`define SCAN_AUX_FN     4'h9
`define SCAN_FIRST_THERMAL_MEASUREMENT      4'hA
`define SCAN_PORT       4'hB
`define SCAN_SECOND_THERMAL_MEASUREMENT      4'hC

// Result register slots and converter channel numbers.
`define CH_FIRST_BATTERY_INPUT         3'h0
`define CH_SECOND_BATTERY_INPUT         3'h1
`define CH_AUX          3'h2
`define CH_FIRST_THERMAL_MEASUREMENT        3'h3
`define CH_SECOND_THERMAL_MEASUREMENT        3'h4
`define CH_NONE         3'h7

// Conversion timing.
`define SYS_MHZ         6'h19
`define EXTRA_PERIODS   5'h04

`endif

/* File: aux_sample_ram.v */
`timescale 1ns/100ps
`default_nettype none

module aux_sample_ram #(
	parameter W  = 12,
	parameter AW = 4
) (
	input  wire          sys_clk,
	input  wire          sys_rst,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [W-1:0]  wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [W-1:0]  rd_data_q
);

	reg [W-1:0] mem [0:(1<<AW)-1];

	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_q <= {W{1'b0}};
		end else begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule // aux_sample_ram

`default_nettype wire

/* File: aux_spi_port.v */
`timescale 1ns/100ps
`default_nettype none

module aux_spi_port (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        spi_sclk,
	input  wire        spi_cs_n,
	input  wire        spi_mosi,
	input  wire [15:0] tx_word,
	output reg         spi_miso_q,
	output reg         spi_miso_oe_q,
	output reg         word_valid_q,
	output reg         first_word_q,
	output reg  [15:0] rx_word_q
);

	reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
	reg        cs_n_s1_q, cs_n_s2_q;
	reg        mosi_s1_q, mosi_s2_q;
	reg [3:0]  bit_cnt_q;
	reg        first_q;
	reg [15:0] rx_sr_q, tx_sr_q;

	wire active = ~cs_n_s2_q;
	wire rise   = sclk_s2_q & ~sclk_s3_q;
	wire fall   = ~sclk_s2_q & sclk_s3_q;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_s1_q     <= 1'b0;
			sclk_s2_q     <= 1'b0;
			sclk_s3_q     <= 1'b0;
			cs_n_s1_q     <= 1'b1;
			cs_n_s2_q     <= 1'b1;
			mosi_s1_q     <= 1'b0;
			mosi_s2_q     <= 1'b0;
			bit_cnt_q     <= 4'h0;
			first_q       <= 1'b1;
			rx_sr_q       <= 16'h0000;
			tx_sr_q       <= 16'h0000;
			rx_word_q     <= 16'h0000;
			word_valid_q  <= 1'b0;
			first_word_q  <= 1'b0;
			spi_miso_q    <= 1'b0;
			spi_miso_oe_q <= 1'b0;
		end else begin
			sclk_s1_q     <= spi_sclk;
			sclk_s2_q     <= sclk_s1_q;
			sclk_s3_q     <= sclk_s2_q;
			cs_n_s1_q     <= spi_cs_n;
			cs_n_s2_q     <= cs_n_s1_q;
			mosi_s1_q     <= spi_mosi;
			mosi_s2_q     <= mosi_s1_q;
			spi_miso_oe_q <= active;
			word_valid_q  <= 1'b0;
			if (!active) begin
				bit_cnt_q  <= 4'h0;
				first_q    <= 1'b1;
				tx_sr_q    <= 16'h0000;
				spi_miso_q <= 1'b0;
			end else begin
				if (rise) begin
					rx_sr_q   <= {rx_sr_q[14:0], mosi_s2_q};
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == 4'hF) begin
						rx_word_q    <= {rx_sr_q[14:0], mosi_s2_q};
						word_valid_q <= 1'b1;
						first_word_q <= first_q;
						first_q      <= 1'b0;
					end
				end
				// Reply words are loaded after a word completes, on the next falling edge.
				if (fall) begin
					if (bit_cnt_q == 4'h0) begin
						tx_sr_q    <= tx_word;
						spi_miso_q <= tx_word[15];
					end else begin
						tx_sr_q    <= {tx_sr_q[14:0], 1'b0};
						spi_miso_q <= tx_sr_q[14];
					end
				end
			end
		end
	end

endmodule // aux_spi_port

`default_nettype wire

/* File: aux_adc_control.v */
`timescale 1ns/100ps
`default_nettype none
`include "aux_adc_consts.vh"

module aux_adc_control #(
	parameter [3:0] SCAN_FIRST_BAT = `SCAN_FIRST_BATTERY_INPUT
) (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        spi_sclk,
	input  wire        spi_cs_n,
	input  wire        spi_mosi,
	input  wire [11:0] adc_sample_in,
	output wire        spi_miso,
	output wire        spi_miso_oe,
	output reg  [2:0]  adc_channel_q,
	output reg         adc_sampling_q,
	output reg         adc_power_down_q,
	output reg         results_ready_q
);

	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_CONV  = 8'h02;
	localparam [7:0] S_SAMP  = 8'h04;
	localparam [7:0] S_CREQ  = 8'h08;
	localparam [7:0] S_CGET  = 8'h10;
	localparam [7:0] S_JREQ  = 8'h20;
	localparam [7:0] S_JGET  = 8'h40;
	localparam [7:0] S_WRITE = 8'h80;

	////////////////////////////////////////////////////////////////////////////
	// Serial port and register access.

	wire        word_valid, first_word;
	wire [15:0] rx_word;
	reg  [15:0] tx_word;

	aux_spi_port u_spi (
		.sys_clk       (sys_clk),
		.sys_rst       (sys_rst),
		.spi_sclk      (spi_sclk),
		.spi_cs_n      (spi_cs_n),
		.spi_mosi      (spi_mosi),
		.tx_word       (tx_word),
		.spi_miso_q    (spi_miso),
		.spi_miso_oe_q (spi_miso_oe),
		.word_valid_q  (word_valid),
		.first_word_q  (first_word),
		.rx_word_q     (rx_word)
	);

	reg         stop_q, filt_q, rd_mode_q, results_set;
	reg  [3:0]  scan_q, page_q, samp_q, i_q, j_q, lt_q, le_q;
	reg  [1:0]  width_q, avg_q, rate_q, seq_q;
	reg  [5:0]  addr_q;
	reg  [7:0]  state_q;
	reg  [5:0]  acc_q;
	reg  [4:0]  tick_cnt_q, new_q;
	reg  [15:0] sum_q;
	reg  [11:0] sync1_q, sync2_q, sample_q, cand_q, result_q;
	reg  [11:0] data_q [0:4];
	integer     k;

	function [2:0] slot_of;
		input [5:0] a;
		begin
			case (a)
				`ADDR_FIRST_BATTERY_INPUT:  slot_of = `CH_FIRST_BATTERY_INPUT;
				`ADDR_SECOND_BATTERY_INPUT:  slot_of = `CH_SECOND_BATTERY_INPUT;
				`ADDR_AUX:   slot_of = `CH_AUX;
				`ADDR_FIRST_THERMAL_MEASUREMENT: slot_of = `CH_FIRST_THERMAL_MEASUREMENT;
				`ADDR_SECOND_THERMAL_MEASUREMENT: slot_of = `CH_SECOND_THERMAL_MEASUREMENT;
				default:     slot_of = `CH_NONE;
			endcase
		end
	endfunction

	wire       busy     = ~state_q[0];
	wire [2:0] rd_slot  = slot_of(addr_q);
	wire       data_wd  = word_valid & ~first_word;
	wire       wr_ctl   = data_wd & ~rd_mode_q & (page_q == `PAGE_CTRL)
	                      & (addr_q == `ADDR_CONTROL);
	wire       rd_data  = data_wd & rd_mode_q & (page_q == `PAGE_DATA)
	                      & (rd_slot != `CH_NONE);

	always @* begin
		tx_word = 16'h0000;
		if (page_q == `PAGE_DATA && rd_slot != `CH_NONE) begin
			tx_word = {4'h0, data_q[rd_slot]};
		end else if (page_q == `PAGE_CTRL && addr_q == `ADDR_CONTROL) begin
			// Bit 15 and bits 3..1 always read zero.
			tx_word = {1'b0, ~busy, scan_q, width_q, avg_q,
			           rate_q, 3'b000, filt_q};
		end else if (page_q == `PAGE_CTRL && addr_q == `ADDR_STATUS) begin
			tx_word[`STAT_PWRDN] = stop_q;
			tx_word[`STAT_READY] = results_ready_q;
			tx_word[6:4]         = {new_q[0], new_q[1], new_q[2]};
			tx_word[2:1]         = {new_q[3], new_q[4]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoded settings.

	reg [4:0] conv_bits, n_samp;
	reg [5:0] rate_mhz;
	reg [3:0] med_k;
	reg [2:0] mean_shift, chan;
	reg       last_in_set;

	always @* begin
		case (width_q)
			2'b01:   conv_bits = 5'h08;
			2'b10:   conv_bits = 5'h0A;
			default: conv_bits = 5'h0C;
		endcase
		case (rate_q)
			2'b00:   rate_mhz = 6'h08;
			2'b01:   rate_mhz = 6'h04;
			2'b10:   rate_mhz = 6'h02;
			default: rate_mhz = 6'h01;
		endcase
		case ({filt_q, avg_q})
			3'b001:  n_samp = 5'h04;
			3'b010:  n_samp = 5'h08;
			3'b011:  n_samp = 5'h10;
			3'b101:  n_samp = 5'h05;
			3'b110:  n_samp = 5'h09;
			3'b111:  n_samp = 5'h0F;
			default: n_samp = 5'h01;
		endcase
		case (avg_q)
			2'b01:   begin med_k = 4'h2; mean_shift = 3'h2; end
			2'b10:   begin med_k = 4'h4; mean_shift = 3'h3; end
			default: begin med_k = 4'h7; mean_shift = 3'h4; end
		endcase
		last_in_set = 1'b1;
		case (scan_q)
			SCAN_FIRST_BAT: chan = `CH_FIRST_BATTERY_INPUT;
			`SCAN_SECOND_BATTERY_INPUT:     chan = `CH_SECOND_BATTERY_INPUT;
			`SCAN_AUX:      chan = `CH_AUX;
			`SCAN_AUX_FN:   chan = `CH_AUX;
			`SCAN_FIRST_THERMAL_MEASUREMENT:    chan = `CH_FIRST_THERMAL_MEASUREMENT;
			`SCAN_SECOND_THERMAL_MEASUREMENT:    chan = `CH_SECOND_THERMAL_MEASUREMENT;
			`SCAN_PORT: begin
				chan        = {1'b0, seq_q};
				last_in_set = (seq_q == 2'h2);
			end
			default:        chan = `CH_NONE;
		endcase
	end

	wire [3:0] wr_scan   = rx_word[`CTL_SCAN_HI:`CTL_SCAN_LO];
	wire       scan_ok   = (wr_scan == SCAN_FIRST_BAT) || (wr_scan == `SCAN_SECOND_BATTERY_INPUT) ||
	                       (wr_scan == `SCAN_AUX) || (wr_scan == `SCAN_AUX_FN) ||
	                       (wr_scan == `SCAN_FIRST_THERMAL_MEASUREMENT) || (wr_scan == `SCAN_PORT) ||
	                       (wr_scan == `SCAN_SECOND_THERMAL_MEASUREMENT);
	wire [5:0] acc_sum   = acc_q + rate_mhz;
	wire       tick      = (acc_sum >= `SYS_MHZ);
	wire [4:0] conv_len  = conv_bits + `EXTRA_PERIODS;
	wire [15:0] sum_n    = sum_q + {4'h0, sample_q};
	wire [15:0] mean_val = sum_n >> mean_shift;
	wire [11:0] trunc    = sync2_q >> (5'h0C - conv_bits);

	////////////////////////////////////////////////////////////////////////////
	// Sample store for the median filter.

	wire [11:0] rd_sample;

	aux_sample_ram #(.W(12), .AW(4)) u_ram (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.wr_en     (state_q == S_SAMP),
		.wr_addr   (samp_q),
		.wr_data   (sample_q),
		.rd_addr   (state_q == S_CREQ ? i_q : j_q),
		.rd_data_q (rd_sample)
	);

	wire [3:0] lt_n = lt_q + {3'h0, rd_sample < cand_q};
	wire [3:0] le_n = le_q + {3'h0, rd_sample <= cand_q};

	////////////////////////////////////////////////////////////////////////////
	// Control register, sequencer and result registers.

	wire [4:0] clr_mask = rd_data ? (5'h01 << rd_slot) : 5'h00;
	wire [4:0] set_mask = (state_q == S_WRITE) ? (5'h01 << chan) : 5'h00;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stop_q           <= 1'b0;
			scan_q           <= `SCAN_NONE;
			width_q          <= 2'b00;
			avg_q            <= 2'b00;
			rate_q           <= 2'b00;
			filt_q           <= 1'b0;
			rd_mode_q        <= 1'b0;
			page_q           <= 4'h0;
			addr_q           <= 6'h00;
			state_q          <= S_IDLE;
			acc_q            <= 6'h00;
			tick_cnt_q       <= 5'h00;
			samp_q           <= 4'h0;
			sum_q            <= 16'h0000;
			sample_q         <= 12'h000;
			cand_q           <= 12'h000;
			result_q         <= 12'h000;
			i_q              <= 4'h0;
			j_q              <= 4'h0;
			lt_q             <= 4'h0;
			le_q             <= 4'h0;
			seq_q            <= 2'h0;
			sync1_q          <= 12'h000;
			sync2_q          <= 12'h000;
			new_q            <= 5'h00;
			results_ready_q  <= 1'b0;
			adc_channel_q    <= `CH_NONE;
			adc_sampling_q   <= 1'b0;
			adc_power_down_q <= 1'b0;
			for (k = 0; k < 5; k = k + 1) begin
				data_q[k] <= 12'h000;
			end
		end else begin
			sync1_q          <= adc_sample_in;
			sync2_q          <= sync1_q;
			adc_channel_q    <= busy ? chan : `CH_NONE;
			adc_sampling_q   <= (state_q == S_CONV);
			adc_power_down_q <= stop_q;
			// A result landing in the cycle its slot is read out stays flagged.
			new_q            <= (new_q & ~clr_mask) | set_mask;
			if (results_set) begin
				results_ready_q <= 1'b1;
			end else if (((new_q & ~clr_mask) | set_mask) == 5'h00) begin
				results_ready_q <= 1'b0;
			end
			if (word_valid) begin
				if (first_word) begin
					rd_mode_q <= rx_word[`CMD_READ];
					page_q    <= rx_word[`CMD_PAGE_HI:`CMD_PAGE_LO];
					addr_q    <= rx_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
				end else begin
					addr_q    <= addr_q + 6'h01;
				end
			end
			case (state_q)
				S_IDLE: begin
				end
				S_CONV: begin
					acc_q <= tick ? acc_sum - `SYS_MHZ : acc_sum;
					if (tick) begin
						if (tick_cnt_q == conv_len - 5'h01) begin
							tick_cnt_q <= 5'h00;
							sample_q   <= trunc;
							state_q    <= S_SAMP;
						end else begin
							tick_cnt_q <= tick_cnt_q + 5'h01;
						end
					end
				end
				S_SAMP: begin
					sum_q <= sum_n;
					if ({1'b0, samp_q} == n_samp - 5'h01) begin
						if (n_samp == 5'h01) begin
							result_q <= sample_q;
							state_q  <= S_WRITE;
						end else if (filt_q) begin
							i_q     <= 4'h0;
							state_q <= S_CREQ;
						end else begin
							result_q <= mean_val[11:0];
							state_q  <= S_WRITE;
						end
					end else begin
						samp_q  <= samp_q + 4'h1;
						state_q <= S_CONV;
					end
				end
				S_CREQ: begin
					state_q <= S_CGET;
				end
				S_CGET: begin
					cand_q  <= rd_sample;
					lt_q    <= 4'h0;
					le_q    <= 4'h0;
					j_q     <= 4'h0;
					state_q <= S_JREQ;
				end
				S_JREQ: begin
					state_q <= S_JGET;
				end
				S_JGET: begin
					lt_q <= lt_n;
					le_q <= le_n;
					if ({1'b0, j_q} == n_samp - 5'h01) begin
						// The candidate is the median when at most k samples lie strictly below it and more than k lie at or below it.
						if (lt_n <= med_k && le_n > med_k) begin
							result_q <= cand_q;
							state_q  <= S_WRITE;
						end else begin
							i_q     <= i_q + 4'h1;
							state_q <= S_CREQ;
						end
					end else begin
						j_q     <= j_q + 4'h1;
						state_q <= S_JREQ;
					end
				end
				S_WRITE: begin
					data_q[chan] <= result_q;
					samp_q       <= 4'h0;
					sum_q        <= 16'h0000;
					acc_q        <= 6'h00;
					if (last_in_set) begin
						state_q <= S_IDLE;
					end else begin
						seq_q   <= seq_q + 2'h1;
						state_q <= S_CONV;
					end
				end
				default: state_q <= S_IDLE;
			endcase
			if (wr_ctl) begin
				stop_q  <= rx_word[`CTL_STOP];
				scan_q  <= wr_scan;
				width_q <= rx_word[`CTL_WIDTH_HI:`CTL_WIDTH_LO];
				avg_q   <= rx_word[`CTL_AVG_HI:`CTL_AVG_LO];
				rate_q  <= rx_word[`CTL_RATE_HI:`CTL_RATE_LO];
				filt_q  <= rx_word[`CTL_FILT];
				seq_q      <= 2'h0;
				samp_q     <= 4'h0;
				sum_q      <= 16'h0000;
				acc_q      <= 6'h00;
				tick_cnt_q <= 5'h00;
				if (rx_word[`CTL_STOP] || !scan_ok) begin
					state_q <= S_IDLE;
				end else begin
					state_q <= S_CONV;
				end
			end
		end
	end

	always @* begin
		results_set = (state_q == S_WRITE) && last_in_set && !wr_ctl;
	end

endmodule // aux_adc_control

`default_nettype wire

/* File: aux_adc_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module aux_adc_control_checker (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       spi_cs_n,
	input wire logic       spi_miso_oe,
	input wire logic [2:0] adc_channel_q,
	input wire logic       adc_sampling_q,
	input wire logic       adc_power_down_q,
	input wire logic       results_ready_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	property p_chan_legal;
		adc_channel_q <= 3'h4 || adc_channel_q == 3'h7;
	endproperty
	a_chan_legal: assert property (p_chan_legal)
		else $error("converter channel outside the five inputs and idle");
	property p_start_chan;
		$rose(adc_sampling_q) |-> adc_channel_q != 3'h7;
	endproperty
	a_start_chan: assert property (p_start_chan)
		else $error("conversion started with no channel selected");
	property p_start_awake;
		$rose(adc_sampling_q) |-> !adc_power_down_q;
	endproperty
	a_start_awake: assert property (p_start_awake)
		else $error("conversion started while powered down");
	property p_pd_quick;
		$rose(adc_power_down_q) |-> ##[0:2] (!adc_sampling_q && adc_channel_q == 3'h7);
	endproperty
	a_pd_quick: assert property (p_pd_quick)
		else $error("conversion not aborted at power down");
	property p_pd_idle;
		adc_power_down_q && $past(adc_power_down_q, 3) |-> !adc_sampling_q;
	endproperty
	a_pd_idle: assert property (p_pd_idle)
		else $error("converter active while powered down");
	property p_conv_min;
		$rose(adc_sampling_q) |-> ##1 (adc_sampling_q || adc_power_down_q) [*8];
	endproperty
	a_conv_min: assert property (p_conv_min)
		else $error("conversion shorter than its tick count");
	property p_ready_idle;
		$rose(results_ready_q) |-> ##[0:3] !adc_sampling_q;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("results flagged while still converting");
	property p_ready_hold;
		spi_cs_n [*6] ##0 results_ready_q |=> results_ready_q;
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("results flag cleared with no read");
	property p_pd_on_write;
		$changed(adc_power_down_q) |-> !$past(spi_cs_n, 2);
	endproperty
	a_pd_on_write: assert property (p_pd_on_write)
		else $error("power down changed outside a host frame");
	// The reply pin enable follows the host's chip select three clocks late.
	property p_oe_follows_cs;
		spi_miso_oe == !$past(spi_cs_n, 3);
	endproperty
	a_oe_follows_cs: assert property (p_oe_follows_cs)
		else $error("reply pin enable does not follow chip select");
endmodule // aux_adc_control_checker

bind aux_adc_control aux_adc_control_checker chk (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.spi_cs_n(spi_cs_n),
	.spi_miso_oe(spi_miso_oe),
	.adc_channel_q(adc_channel_q),
	.adc_sampling_q(adc_sampling_q),
	.adc_power_down_q(adc_power_down_q),
	.results_ready_q(results_ready_q)
);

`default_nettype wire

/* File: aux_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none

module aux_spi_host (
	input  wire logic sys_clk,
	input  wire logic spi_miso,
	output var  logic spi_sclk,
	output var  logic spi_cs_n,
	output var  logic spi_mosi
);
	localparam int HALF = 8;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic word(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = tx[i];
			wait_clk(HALF);
			spi_sclk = 1'b1;
			rx[i] = spi_miso;
			wait_clk(HALF);
			spi_sclk = 1'b0;
		end
	endtask

	// A frame is one command word and one data word; the clock rests low between frames.
	task automatic frame(input logic [15:0] cmd, input logic [15:0] tx, output logic [15:0] rx);
		logic [15:0] dummy;
		spi_cs_n = 1'b0;
		wait_clk(HALF);
		word(cmd, dummy);
		word(cmd[15] ? tx : {1'b0, tx[14:0]}, rx);
		wait_clk(2 * HALF);
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		wait_clk(4 * HALF);
	endtask
endmodule // aux_spi_host

`default_nettype wire

/* File: aux_adc_control_test.sv */
`timescale 1ns/100ps
`default_nettype none

module aux_adc_control_test;
	typedef struct {
		logic [15:0] ctl;
		logic [5:0]  addr;
		logic [15:0] res;
		int          lo;
		int          hi;
	} row_t;

	logic        sys_clk, sys_rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
	logic [11:0] adc_sample_in;
	logic [2:0]  adc_channel_q;
	logic        adc_sampling_q, adc_power_down_q, results_ready_q;
	logic [15:0] rd;
	int          n_errors, checks_done, cycles, busy_cyc;
	// Rates are paired with widths the host may use; zero bounds skip the timing check.
	row_t        rows [6] = '{
		'{16'h1430, 6'h05, 16'h09C3, 398, 402},
		'{16'h1F60, 6'h06, 16'h0AD4, 0, 0},
		'{16'h2181, 6'h07, 16'h00BE, 0, 0},
		'{16'h26D0, 6'h07, 16'h02F9, 0, 0},
		'{16'h28E1, 6'h09, 16'h0CF6, 0, 0},
		'{16'h3100, 6'h0A, 16'h00E0, 36, 39}};

	aux_adc_control uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .adc_sample_in(adc_sample_in),
		.spi_miso(spi_miso), .spi_miso_oe(), .adc_channel_q(adc_channel_q),
		.adc_sampling_q(adc_sampling_q), .adc_power_down_q(adc_power_down_q),
		.results_ready_q(results_ready_q));
	aux_spi_host host (.sys_clk(sys_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr_ctl(input logic [15:0] v);
		host.frame(16'h0800, v, rd);
	endtask

	task automatic rd_reg(input logic [3:0] pg, input logic [5:0] a);
		host.frame({1'b1, pg, a, 5'h00}, 16'h0000, rd);
	endtask

	task automatic wait_ready;
		for (int i = 0; i < 20000 && results_ready_q !== 1'b1; i++) begin
			@(negedge sys_clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Each input gets its own code so that results landing in the wrong register show.
	always @(negedge sys_clk) adc_sample_in <= 12'h9C3 + 12'h111 * {9'h000, adc_channel_q};

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (adc_sampling_q === 1'b1) begin
			busy_cyc <= busy_cyc + 1;
		end
		if (cycles == 60000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		sys_rst = 1'b1;
		adc_sample_in = 12'h000;
		n_errors = 0;
		checks_done = 0;
		cycles = 0;
		busy_cyc = 0;
		repeat (3) @(negedge sys_clk);
		check("reset channel", {13'h0000, adc_channel_q}, 16'h0007);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		check("reset power", {15'h0000, adc_power_down_q}, 16'h0000);
		rd_reg(4'h1, 6'h00);
		check("control reset", rd, 16'h4000);
		foreach (rows[i]) begin
			busy_cyc = 0;
			wr_ctl(rows[i].ctl | 16'h000E);
			wait_ready();
			check("ready set", {15'h0000, results_ready_q}, 16'h0001);
			if (rows[i].hi > 0) begin
				check("conv time", {15'h0000, busy_cyc >= rows[i].lo && busy_cyc <= rows[i].hi},
					16'h0001);
			end
			rd_reg(4'h0, rows[i].addr);
			check("result", rd, rows[i].res);
			check("ready clear", {15'h0000, results_ready_q}, 16'h0000);
			rd_reg(4'h1, 6'h00);
			check("control read", rd, rows[i].ctl | 16'h4000);
		end
		wr_ctl(16'h2C30);
		wait_ready();
		rd_reg(4'h0, 6'h07);
		check("scan aux", rd, 16'h0BE5);
		check("ready held", {15'h0000, results_ready_q}, 16'h0001);
		rd_reg(4'h0, 6'h06);
		check("scan second_battery_input", rd, 16'h0AD4);
		rd_reg(4'h0, 6'h05);
		check("scan first_battery_input", rd, 16'h09C3);
		check("ready done", {15'h0000, results_ready_q}, 16'h0000);
		wr_ctl(16'h28F0);
		rd_reg(4'h1, 6'h00);
		check("busy read", rd, 16'h28F0);
		wr_ctl(16'h68F0);
		check("power down", {15'h0000, adc_power_down_q}, 16'h0001);
		check("aborted", {15'h0000, adc_sampling_q}, 16'h0000);
		check("abort channel", {13'h0000, adc_channel_q}, 16'h0007);
		rd_reg(4'h1, 6'h00);
		check("stop read", rd, 16'h68F0);
		check("no result", {15'h0000, results_ready_q}, 16'h0000);
		wr_ctl(16'h0000);
		check("awake", {15'h0000, adc_power_down_q}, 16'h0000);
		results();
	end
endmodule // aux_adc_control_test

`default_nettype wire
